// ### dmia_addr_resolve.v
// Effective address formation for direct and indirect accesses
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_addr_resolve (
  input  wire [`DMIA_ADDR_W-1:0]   i_addr,
  input  wire [`DMIA_PTR_W-1:0]    i_mptr0,
  input  wire [`DMIA_PTR_W-1:0]    i_mptr1,
  input  wire [`DMIA_BANK_W-1:0]   i_bank_select,
  output reg  [`DMIA_ADDR_W-1:0]   o_eff_addr,
  output reg                       o_void
);

  always @* begin
    o_void = 1'b0;
    if (i_addr == `DMIA_OFS_PORT0) begin
      o_eff_addr = {1'b0, i_mptr0};
    end else if (i_addr == `DMIA_OFS_PORT1) begin
      o_eff_addr = {i_bank_select, i_mptr1};
    end else begin
      // Direct reach is bank zero only; above it nothing answers
      o_eff_addr = {1'b0, i_addr[`DMIA_PTR_W-1:0]};
      o_void = i_addr[`DMIA_ADDR_W-1];
    end
  end

endmodule

// ### dmia_core_model.sv
// Program memory side of the core, answering table fetches
`timescale 1ns/1ps

module dmia_core_model (
  input  wire        i_clock,
  input  wire        i_pm_req,
  input  wire [7:0]  i_pm_addr,
  output wire [15:0] o_pm_data
);
  reg [15:0] junk_q = 16'h0000;

  always @(posedge i_clock) begin
    junk_q <= junk_q + 16'h9e37;
  end

  // Word valid only in the fetch cycle; churns otherwise
  assign o_pm_data = i_pm_req ? {~i_pm_addr, i_pm_addr} : junk_q;
endmodule

// ### dmia_data_memory.v
// Data memory unit: special registers, indirect ports, table read
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_data_memory (
  input  wire                      i_clock,
  input  wire                      i_rst_n,
  // Data access from the core
  input  wire                      i_acc_valid,
  input  wire                      i_acc_write,
  input  wire [`DMIA_ADDR_W-1:0]   i_acc_addr,
  input  wire [`DMIA_DATA_W-1:0]   i_acc_wdata,
  input  wire                      i_bit_op,
  input  wire [2:0]                i_bit_sel,
  input  wire                      i_bit_val,
  output wire [`DMIA_DATA_W-1:0]   o_rdata,
  output wire                      o_rvalid,
  // ALU result into the work register
  input  wire                      i_alu_valid,
  input  wire [`DMIA_DATA_W-1:0]   i_alu_result,
  output wire [`DMIA_DATA_W-1:0]   o_work_register,
  // Bank select and program counter
  input  wire [`DMIA_BANK_W-1:0]   i_bank_select,
  input  wire [`DMIA_DATA_W-1:0]   i_pc_low,
  output wire                      o_pc_load,
  output wire [`DMIA_DATA_W-1:0]   o_pc_target,
  // Table read
  input  wire                      i_tbl_req,
  input  wire [`DMIA_ADDR_W-1:0]   i_tbl_dest,
  output wire                      o_pm_req,
  output wire [`DMIA_DATA_W-1:0]   o_pm_addr,
  input  wire [`DMIA_PM_W-1:0]     i_pm_data,
  output wire                      o_tbl_done,
  output wire                      o_busy
);

  // Table read sequence states
  localparam ST_IDLE  = 1'b0;
  localparam ST_FETCH = 1'b1;

  // Storage
  reg  [`DMIA_PTR_W-1:0]   mptr0_q;
  reg  [`DMIA_PTR_W-1:0]   mptr1_q;
  reg  [`DMIA_DATA_W-1:0]  work_q;
  reg  [`DMIA_DATA_W-1:0]  tptr_q;
  reg  [`DMIA_DATA_W-1:0]  thigh_q;
  reg                      state_q;
  reg  [`DMIA_ADDR_W-1:0]  dest_q;
  // Output flops
  reg  [`DMIA_DATA_W-1:0]  rdata_q;
  reg                      rvalid_q;
  reg                      pc_load_q;
  reg  [`DMIA_DATA_W-1:0]  pc_target_q;
  reg                      pm_req_q;
  reg  [`DMIA_DATA_W-1:0]  pm_addr_q;
  reg                      tbl_done_q;
  reg                      busy_q;

  // Combinational path
  wire                     fetching;
  wire                     take_tbl;
  wire                     take_acc;
  wire [`DMIA_ADDR_W-1:0]  raw_addr;
  wire [`DMIA_ADDR_W-1:0]  eff_addr;
  wire                     eff_void;
  wire [`DMIA_DATA_W-1:0]  gp_rd;
  reg  [`DMIA_DATA_W-1:0]  cur_val;
  reg  [`DMIA_DATA_W-1:0]  wr_val;
  wire                     wr_en;
  wire                     gp_wr;
  wire                     sfr_ro;
  // Write strobes of the special registers
  wire                     wr_mptr0;
  wire                     wr_mptr1;
  wire                     wr_work;
  wire                     wr_tptr;
  wire                     wr_pclo;

  function is_gp;
    input [`DMIA_ADDR_W-1:0] a;
    begin
      is_gp = (a >= `DMIA_GP_BASE) && (a <= `DMIA_GP_LAST);
    end
  endfunction

  // Exact match of a resolved address
  function hits;
    input [`DMIA_ADDR_W-1:0] a;
    input [`DMIA_ADDR_W-1:0] ofs;
    begin
      hits = (a == ofs);
    end
  endfunction

  assign fetching = (state_q == ST_FETCH);
  // No new work during a fetch or the dummy cycle after a jump
  assign take_tbl = i_tbl_req && !busy_q;
  assign take_acc = i_acc_valid && !i_tbl_req && !busy_q;

  // Table fetch completes through the same write path as the core
  assign raw_addr = fetching ? dest_q : i_acc_addr;

  dmia_addr_resolve u_resolve (
    .i_addr        (raw_addr),
    .i_mptr0       (mptr0_q),
    .i_mptr1       (mptr1_q),
    .i_bank_select (i_bank_select),
    .o_eff_addr    (eff_addr),
    .o_void        (eff_void)
  );

  // Ports are not physical and the table high byte is read-only
  assign sfr_ro = hits(eff_addr, `DMIA_OFS_PORT0) ||
                  hits(eff_addr, `DMIA_OFS_PORT1) ||
                  hits(eff_addr, `DMIA_OFS_THIGH);
  assign wr_en = !eff_void && !sfr_ro &&
                 (fetching || (take_acc && i_acc_write));
  assign gp_wr = wr_en && is_gp(eff_addr);
  assign wr_mptr0 = wr_en && hits(eff_addr, `DMIA_OFS_MPTR0);
  assign wr_mptr1 = wr_en && hits(eff_addr, `DMIA_OFS_MPTR1);
  assign wr_work  = wr_en && hits(eff_addr, `DMIA_OFS_WORK);
  assign wr_tptr  = wr_en && hits(eff_addr, `DMIA_OFS_TPTR);
  assign wr_pclo  = wr_en && hits(eff_addr, `DMIA_OFS_PCLO);

  dmia_gp_ram u_ram (
    .i_clock   (i_clock),
    .i_wr_en   (gp_wr),
    .i_wr_addr (eff_addr[`DMIA_GP_AW-1:0]),
    .i_wr_data (wr_val),
    .i_rd_addr (eff_addr[`DMIA_GP_AW-1:0]),
    .o_rd_data (gp_rd)
  );

  // Current contents at the effective address
  always @* begin
    if (eff_void) begin
      cur_val = `DMIA_RD_UNUSED;
    end else begin
      case (eff_addr)
        `DMIA_OFS_PORT0: cur_val = `DMIA_RD_UNUSED;
        `DMIA_OFS_PORT1: cur_val = `DMIA_RD_UNUSED;
        `DMIA_OFS_MPTR0: cur_val = {`DMIA_PTR_MSB_RD, mptr0_q};
        `DMIA_OFS_MPTR1: cur_val = {`DMIA_PTR_MSB_RD, mptr1_q};
        `DMIA_OFS_WORK:  cur_val = work_q;
        `DMIA_OFS_PCLO:  cur_val = i_pc_low;
        `DMIA_OFS_TPTR:  cur_val = tptr_q;
        `DMIA_OFS_THIGH: cur_val = thigh_q;
        default: begin
          if (is_gp(eff_addr)) begin
            cur_val = gp_rd;
          end else begin
            cur_val = `DMIA_RD_UNUSED;
          end
        end
      endcase
    end
  end

  // Value to store: table low byte, a single bit, or a whole byte
  always @* begin
    wr_val = i_acc_wdata;
    if (fetching) begin
      wr_val = i_pm_data[`DMIA_DATA_W-1:0];
    end else if (i_bit_op) begin
      wr_val = cur_val;
      wr_val[i_bit_sel] = i_bit_val;
    end
  end

  // Access strobe: one cycle per accepted request
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= take_acc;
    end
  end

  // Pre-write contents, so a modify sees the old byte
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= `DMIA_RST_BYTE;
    end else if (take_acc) begin
      rdata_q <= cur_val;
    end
  end

  // Pointers keep seven bits; bit 7 is rebuilt on read
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mptr0_q <= `DMIA_RST_PTR;
    end else if (wr_mptr0) begin
      mptr0_q <= wr_val[`DMIA_PTR_W-1:0];
    end
  end

  // Pair one pointer; its bank comes from outside
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mptr1_q <= `DMIA_RST_PTR;
    end else if (wr_mptr1) begin
      mptr1_q <= wr_val[`DMIA_PTR_W-1:0];
    end
  end

  // ALU result first; a data write to the same register overrides
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      work_q <= `DMIA_RST_BYTE;
    end else if (wr_work) begin
      work_q <= wr_val;
    end else if (i_alu_valid) begin
      work_q <= i_alu_result;
    end
  end

  // Table pointer is plain storage; software steps it by writes
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tptr_q <= `DMIA_RST_BYTE;
    end else if (wr_tptr) begin
      tptr_q <= wr_val;
    end
  end

  // Only the low byte is replaced, so a jump stays in its page
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_load_q <= 1'b0;
    end else begin
      pc_load_q <= wr_pclo;
    end
  end

  // Target holds until the next jump
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_target_q <= `DMIA_RST_BYTE;
    end else if (wr_pclo) begin
      pc_target_q <= wr_val;
    end
  end

  // Fetch cycle, or the dummy cycle after a jump; requests dropped
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= take_tbl || wr_pclo;
    end
  end

  // Two-cycle table read: request, then the fetched word lands
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take_tbl) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Request strobe for the program word
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pm_req_q <= 1'b0;
    end else begin
      pm_req_q <= take_tbl;
    end
  end

  // Pointer and destination latched as the request is taken
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pm_addr_q <= `DMIA_RST_PM_ADDR;
      dest_q    <= `DMIA_RST_BYTE;
    end else if (take_tbl) begin
      pm_addr_q <= tptr_q;
      dest_q    <= i_tbl_dest;
    end
  end

  // Only hardware loads the high byte
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      thigh_q <= `DMIA_RST_BYTE;
    end else if (fetching) begin
      thigh_q <= i_pm_data[`DMIA_PM_W-1:`DMIA_DATA_W];
    end
  end

  // Done follows the fetch cycle, with busy low unless the fetched byte went to the program counter low
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tbl_done_q <= 1'b0;
    end else begin
      tbl_done_q <= fetching;
    end
  end

  assign o_rdata         = rdata_q;
  assign o_rvalid        = rvalid_q;
  assign o_work_register = work_q;
  assign o_pc_load       = pc_load_q;
  assign o_pc_target     = pc_target_q;
  assign o_pm_req        = pm_req_q;
  assign o_pm_addr       = pm_addr_q;
  assign o_tbl_done      = tbl_done_q;
  assign o_busy          = busy_q;

endmodule

// ### dmia_data_memory_sva.sv
// Port-level assertions for the data memory unit
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_data_memory_sva (
  input wire       i_clock,
  input wire       i_rst_n,
  input wire       i_acc_valid,
  input wire       i_acc_write,
  input wire [7:0] i_acc_addr,
  input wire [7:0] i_acc_wdata,
  input wire       i_bit_op,
  input wire       i_alu_valid,
  input wire [7:0] i_alu_result,
  input wire       i_tbl_req,
  input wire [7:0] o_rdata,
  input wire       o_rvalid,
  input wire [7:0] o_work_register,
  input wire       o_pc_load,
  input wire [7:0] o_pc_target,
  input wire       o_pm_req,
  input wire       o_tbl_done,
  input wire       o_busy
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  wire acc_ok = i_acc_valid && !i_tbl_req && !o_busy;
  wire pc_wr  = acc_ok && i_acc_write && i_acc_addr == `DMIA_OFS_PCLO;

  a_rvalid_taken: assert property (acc_ok |=> o_rvalid)
    else $error("access accepted without rvalid");
  a_rvalid_refused: assert property (!acc_ok |=> !o_rvalid)
    else $error("rvalid without accepted access");
  a_ptr_msb_one: assert property ((acc_ok && (i_acc_addr == 8'h01 ||
    i_acc_addr == 8'h03)) |=> o_rdata[7])
    else $error("pointer bit 7 read as zero");
  a_unused_zero: assert property ((acc_ok && (i_acc_addr == 8'h04 ||
    i_acc_addr[7])) |=> o_rdata == `DMIA_RD_UNUSED)
    else $error("unused or high address read nonzero");
  a_jump_load: assert property ((pc_wr && !i_bit_op) |=> o_pc_load &&
    o_busy && o_pc_target == $past(i_acc_wdata))
    else $error("program counter write gave no jump");
  a_jump_cause: assert property (o_pc_load |->
    ($past(acc_ok && i_acc_write) || $past(o_pm_req)))
    else $error("jump without program counter write");
  a_busy_single: assert property (o_busy |=> (!o_busy || o_pc_load))
    else $error("busy longer than one cycle");
  a_dummy_once: assert property (o_pc_load |=> !o_busy && !o_pc_load)
    else $error("dummy cycle not single");
  a_table_seq: assert property ((i_tbl_req && !o_busy) |=>
    (o_pm_req && o_busy) ##1 (o_tbl_done && (!o_busy || o_pc_load)))
    else $error("table read not two cycles");
  a_done_cause: assert property (o_tbl_done |-> $past(o_pm_req))
    else $error("table done without fetch");
  a_alu_load: assert property ((i_alu_valid && !i_acc_valid && !o_pm_req)
    |=> o_work_register == $past(i_alu_result))
    else $error("alu result not in work register");

  c_table: cover property (o_tbl_done);
  c_jump: cover property (o_pc_load);
  c_ptr_read: cover property (o_rvalid && o_rdata[7]);
endmodule

// ### dmia_data_memory_test.sv
// Self-checking bench for the data memory unit
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_data_memory_test;
  reg         i_clock = 1'b0;
  reg         i_rst_n = 1'b0;
  reg         i_acc_valid = 1'b0;
  reg         i_acc_write = 1'b0;
  reg  [7:0]  i_acc_addr = 8'h00;
  reg  [7:0]  i_acc_wdata = 8'h00;
  reg         i_bit_op = 1'b0;
  reg  [2:0]  i_bit_sel = 3'h0;
  reg         i_bit_val = 1'b0;
  reg         i_alu_valid = 1'b0;
  reg  [7:0]  i_alu_result = 8'h00;
  reg         i_bank_select = 1'b0;
  reg  [7:0]  i_pc_low = 8'h00;
  reg         i_tbl_req = 1'b0;
  reg  [7:0]  i_tbl_dest = 8'h00;
  wire [15:0] i_pm_data;
  wire [7:0]  o_rdata, o_work_register, o_pc_target, o_pm_addr;
  wire        o_rvalid, o_pc_load, o_pm_req, o_tbl_done, o_busy;
  integer     errors = 0;
  integer     check_count = 0;
  reg  [7:0]  rd;

  dmia_data_memory i_dut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_acc_valid(i_acc_valid),
    .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr),
    .i_acc_wdata(i_acc_wdata), .i_bit_op(i_bit_op),
    .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .i_alu_valid(i_alu_valid),
    .i_alu_result(i_alu_result), .o_work_register(o_work_register),
    .i_bank_select(i_bank_select), .i_pc_low(i_pc_low),
    .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
    .i_tbl_req(i_tbl_req), .i_tbl_dest(i_tbl_dest),
    .o_pm_req(o_pm_req), .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data),
    .o_tbl_done(o_tbl_done), .o_busy(o_busy));
  dmia_core_model i_core (.i_clock(i_clock), .i_pm_req(o_pm_req),
    .i_pm_addr(o_pm_addr), .o_pm_data(i_pm_data));

  initial begin
    forever #2.5 i_clock = ~i_clock;
  end

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Bit op reuses data: index in [2:0], new value in [3]
  task drive(input w, input [7:0] a, input [7:0] d, input b);
    begin
      i_acc_valid <= 1'b1;
      i_acc_write <= w;
      i_acc_addr  <= a;
      i_acc_wdata <= d;
      i_bit_op    <= b;
      i_bit_sel   <= d[2:0];
      i_bit_val   <= d[3];
    end
  endtask

  task acc(input w, input [7:0] a, input [7:0] d, input b);
    begin
      @(posedge i_clock);
      drive(w, a, d, b);
      @(posedge i_clock);
      i_acc_valid <= 1'b0;
      #1 chk(o_rvalid, 1'b1);
      rd = o_rdata;
    end
  endtask

  task rdchk(input [7:0] a, input [7:0] e);
    begin
      acc(0, a, 8'h00, 0);
      chk(rd, e);
    end
  endtask

  task t_gp;
    begin
      acc(1, 8'h40, 8'h5a, 0);
      acc(1, 8'h5f, 8'hc3, 0);
      rdchk(8'h40, 8'h5a);
      rdchk(8'h5f, 8'hc3);
      acc(1, 8'h40, 8'h0f, 1);
      acc(1, 8'h40, 8'h01, 1);
      rdchk(8'h40, 8'hd8);
      $display("t_gp done");
    end
  endtask

  task t_ptr;
    begin
      acc(1, `DMIA_OFS_MPTR0, 8'h7f, 0);
      chk(rd, 8'h80);
      rdchk(`DMIA_OFS_MPTR0, 8'hff);
      acc(1, `DMIA_OFS_MPTR0, 8'hc1, 0);
      rdchk(`DMIA_OFS_MPTR0, 8'hc1);
      acc(1, `DMIA_OFS_PORT0, 8'h3c, 0);
      rdchk(8'h41, 8'h3c);
      acc(1, `DMIA_OFS_MPTR0, 8'h02, 0);
      rdchk(`DMIA_OFS_PORT0, 8'h00);
      acc(1, `DMIA_OFS_MPTR1, 8'h5f, 0);
      rdchk(`DMIA_OFS_PORT1, 8'hc3);
      @(posedge i_clock);
      i_bank_select <= 1'b1;
      acc(1, `DMIA_OFS_PORT1, 8'h99, 0);
      rdchk(`DMIA_OFS_PORT1, 8'h00);
      @(posedge i_clock);
      i_bank_select <= 1'b0;
      rdchk(8'h5f, 8'hc3);
      rdchk(8'hdf, 8'h00);
      $display("t_ptr done");
    end
  endtask

  task t_misc;
    begin
      rdchk(8'h04, 8'h00);
      acc(1, `DMIA_OFS_THIGH, 8'h77, 0);
      rdchk(`DMIA_OFS_THIGH, 8'h00);
      @(posedge i_clock);
      i_alu_valid  <= 1'b1;
      i_alu_result <= 8'h96;
      @(posedge i_clock);
      i_alu_valid <= 1'b0;
      #1 chk(o_work_register, 8'h96);
      rdchk(`DMIA_OFS_WORK, 8'h96);
      $display("t_misc done");
    end
  endtask

  task t_jump;
    begin
      @(posedge i_clock);
      i_pc_low <= 8'h3a;
      drive(1, `DMIA_OFS_PCLO, 8'h9b, 0);
      @(posedge i_clock);
      // Request kept up into the dummy cycle must be dropped
      i_acc_write <= 1'b0;
      i_acc_addr  <= 8'h04;
      #1 chk(o_pc_load, 1'b1);
      chk(o_pc_target, 8'h9b);
      chk(o_busy, 1'b1);
      @(posedge i_clock);
      i_acc_valid <= 1'b0;
      #1 chk(o_rvalid, 1'b0);
      chk(o_pc_load, 1'b0);
      rdchk(`DMIA_OFS_PCLO, 8'h3a);
      $display("t_jump done");
    end
  endtask

  task t_table;
    begin
      acc(1, `DMIA_OFS_TPTR, 8'h27, 0);
      @(posedge i_clock);
      i_tbl_req  <= 1'b1;
      i_tbl_dest <= 8'h42;
      @(posedge i_clock);
      i_tbl_req <= 1'b0;
      #1 chk(o_pm_req, 1'b1);
      chk(o_pm_addr, 8'h27);
      @(posedge i_clock);
      #1 chk(o_tbl_done, 1'b1);
      chk(o_busy, 1'b0);
      rdchk(`DMIA_OFS_THIGH, 8'hd8);
      rdchk(8'h42, 8'h27);
      acc(1, `DMIA_OFS_THIGH, 8'h55, 0);
      rdchk(`DMIA_OFS_THIGH, 8'hd8);
      $display("t_table done");
    end
  endtask

  task close_out;
    begin
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_gp;
    t_ptr;
    t_misc;
    t_jump;
    t_table;
    close_out;
  end

  initial begin
    #100000;
    errors = errors + 1;
    close_out;
  end
endmodule

bind dmia_data_memory dmia_data_memory_sva i_sva (
  .i_clock(i_clock), .i_rst_n(i_rst_n), .i_acc_valid(i_acc_valid),
  .i_acc_write(i_acc_write), .i_acc_addr(i_acc_addr),
  .i_acc_wdata(i_acc_wdata), .i_bit_op(i_bit_op),
  .i_alu_valid(i_alu_valid), .i_alu_result(i_alu_result),
  .i_tbl_req(i_tbl_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_work_register(o_work_register), .o_pc_load(o_pc_load),
  .o_pc_target(o_pc_target), .o_pm_req(o_pm_req),
  .o_tbl_done(o_tbl_done), .o_busy(o_busy)
);

// ### dmia_defs.vh
// Constants for the data memory and indirect access unit
`ifndef DMIA_DEFS_VH
`define DMIA_DEFS_VH

`define DMIA_DATA_W       8
`define DMIA_ADDR_W       8
`define DMIA_PTR_W        7
`define DMIA_BANK_W       1
`define DMIA_PM_W         16

`define DMIA_OFS_PORT0    8'h00
`define DMIA_OFS_MPTR0    8'h01
`define DMIA_OFS_PORT1    8'h02
`define DMIA_OFS_MPTR1    8'h03
`define DMIA_OFS_WORK     8'h05
`define DMIA_OFS_PCLO     8'h06
`define DMIA_OFS_TPTR     8'h07
`define DMIA_OFS_THIGH    8'h08

`define DMIA_GP_BASE      8'h40
`define DMIA_GP_LAST      8'h5f
`define DMIA_GP_DEPTH     32
`define DMIA_GP_AW        5

`define DMIA_PTR_MSB_RD   1'b1
`define DMIA_RD_UNUSED    8'h00

`define DMIA_RST_PTR      7'h00
`define DMIA_RST_BYTE     8'h00
`define DMIA_RST_PM_ADDR  8'h00

`endif

// ### dmia_gp_ram.v
// General purpose byte storage of bank zero
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_gp_ram (
  input  wire                      i_clock,
  input  wire                      i_wr_en,
  input  wire [`DMIA_GP_AW-1:0]    i_wr_addr,
  input  wire [`DMIA_DATA_W-1:0]   i_wr_data,
  input  wire [`DMIA_GP_AW-1:0]    i_rd_addr,
  output wire [`DMIA_DATA_W-1:0]   o_rd_data
);

  // Volatile: contents undefined until written, so no reset
  reg [`DMIA_DATA_W-1:0] mem_q [0:`DMIA_GP_DEPTH-1];

  always @(posedge i_clock) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  // Combinational read lets a bit op modify a byte in one cycle
  assign o_rd_data = mem_q[i_rd_addr];

endmodule
